// file: apc_pkg.sv
// constants for the record-path control register bank
// assumes one clock domain, registers reached over the device control port
// Summary of operation
// [R1] new left/right gains wait until a 1 is written to either update bit 8
// [R2] right gain code 0 mutes; code 1 is -71.625dB, 0.375dB per code up
// [R3] left side-tone field bits 11:8 gives -36dB to 0dB in 3dB steps
// [R4] right side-tone field bits 7:4 gives -36dB to 0dB in 3dB steps
// [R5] rate divider divides master clock by 1,1.5,2,3,4,5.5,6; code 7 reserved
// [R6] frame clock is generated only while enable bit 11 is set
// [R7] period field sets bit clocks per frame phase 8..2047, reset 64
// [R8] right routing bits 10,9,8 connect second, first-neg, first-pos pins
// [R9] left routing bits 2,1,0 connect second, first-neg, first-pos pins
// [R10] right aux amp powered by bit 15; bit 14 bypasses its input resistor
// [R11] left aux amp powered by bit 7; bit 6 bypasses its input resistor
// [R12] left volume register bit 15 enables left channel, holds latch and gain
// [R13] right enable bit 15 and clock invert bit 3 are plain stored controls; here bit 3 also inverts recordClock
// [R14] update latch write is a one-shot transfer; it always reads zero
package apc_pkg;
  localparam logic [6:0] ADDR_LEFT_GAIN = 7'h42;
  localparam logic [6:0] ADDR_RIGHT_GAIN = 7'h43;
  localparam logic [6:0] ADDR_DIV_SIDETONE = 7'h44;
  localparam logic [6:0] ADDR_FRAME_RATE = 7'h46;
  localparam logic [6:0] ADDR_ROUTING = 7'h48;
  localparam logic [6:0] ADDR_AUX_AMP = 7'h49;
  localparam logic [7:0] RST_GAIN = 8'hC0;
  localparam logic [10:0] RST_FRAME_PERIOD = 11'h040;
  localparam logic [5:0] RST_ROUTING = 6'h1B;
  localparam int BIT_CHANNEL_ON = 15;
  localparam int BIT_VOLUME_UPDATE = 8;
  localparam int BIT_CLOCK_INVERT = 3;
  localparam int BIT_FRAME_GEN_ON = 11;
  localparam int BIT_RIGHT_SECOND = 10;
  localparam int BIT_RIGHT_NEG = 9;
  localparam int BIT_RIGHT_POS = 8;
  localparam int BIT_LEFT_SECOND = 2;
  localparam int BIT_LEFT_NEG = 1;
  localparam int BIT_LEFT_POS = 0;
  localparam int BIT_RIGHT_AUX_ON = 15;
  localparam int BIT_RIGHT_AUX_BYPASS = 14;
  localparam int BIT_LEFT_AUX_ON = 7;
  localparam int BIT_LEFT_AUX_BYPASS = 6;
  localparam logic [10:0] GAIN_EIGHTHS_OFFSET = 11'h240;
  localparam logic [5:0] SIDETONE_MAX_ATTEN = 6'h24;
  localparam logic [3:0] SIDETONE_ZERO_CODE = 4'hC;
  localparam logic [10:0] MIN_FRAME_PERIOD = 11'h008;
  localparam logic [2:0] RATE_CODE_RESERVED = 3'h7;
  localparam logic [4:0] RATE_ACC_STEP = 5'h02;
endpackage

// file: apc_clk_if.sv
// control and status signals between the register bank and the clock generator
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface apc_clk_if;
  logic [2:0] rateCode;
  logic clockInvert;
  logic frameGenOn;
  logic [10:0] framePeriod;
  logic rateTick;
  logic recordClock;
  logic frameClock;
  modport regs (output rateCode, clockInvert, frameGenOn, framePeriod,
    input rateTick, recordClock, frameClock);
  modport gen (input rateCode, clockInvert, frameGenOn, framePeriod,
    output rateTick, recordClock, frameClock);
endinterface
`default_nettype wire

// file: apc_clock_gen.sv
// record sample-rate divider and frame clock generator
// assumes bitClkTick is a one-cycle pulse synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module apc_clock_gen (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic bitClkTick,
  apc_clk_if.gen clkIf
);
  logic [4:0] acc_q, acc_d;
  logic [4:0] threshold;
  logic [4:0] accSum;
  logic tick_d, tick_q;
  logic level_q, level_d;
  logic [10:0] cnt_q, cnt_d;
  logic frame_q, frame_d;
  logic [10:0] periodEff;

  ////////////////////////////////////////////////////////////////////////////
  // fractional divide: accumulate 2 per master clock against twice the ratio
  always_comb begin
    case (clkIf.rateCode) // R5
      3'h0: threshold = 5'h02;
      3'h1: threshold = 5'h03;
      3'h2: threshold = 5'h04;
      3'h3: threshold = 5'h06;
      3'h4: threshold = 5'h08;
      3'h5: threshold = 5'h0B;
      3'h6: threshold = 5'h0C;
      default: threshold = 5'h00;
    endcase
    accSum = acc_q + apc_pkg::RATE_ACC_STEP;
    acc_d = acc_q;
    tick_d = 1'b0;
    level_d = level_q;
    // reserved code stops the divider rather than guessing a ratio
    if (clkIf.rateCode == apc_pkg::RATE_CODE_RESERVED) begin // R5
      acc_d = 5'h00;
    end else if (accSum >= threshold) begin
      acc_d = accSum - threshold;
      tick_d = 1'b1;
      level_d = ~level_q;
    end else begin
      acc_d = accSum;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 5'h00;
      tick_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
      level_q <= level_d;
    end
  end

  assign clkIf.rateTick = tick_q;
  assign clkIf.recordClock = level_q ^ clkIf.clockInvert; // R13

  ////////////////////////////////////////////////////////////////////////////
  // frame clock: invalid periods below 8 are clamped so the counter never stalls
  always_comb begin
    periodEff = (clkIf.framePeriod < apc_pkg::MIN_FRAME_PERIOD) ?
      apc_pkg::MIN_FRAME_PERIOD : clkIf.framePeriod; // R7
    cnt_d = cnt_q;
    frame_d = frame_q;
    if (!clkIf.frameGenOn) begin // R6
      cnt_d = 11'h000;
      frame_d = 1'b0;
    end else if (bitClkTick) begin
      if (cnt_q + 11'h001 >= periodEff) begin // R7
        cnt_d = 11'h000;
        frame_d = ~frame_q;
      end else begin
        cnt_d = cnt_q + 11'h001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 11'h000;
      frame_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      frame_q <= frame_d;
    end
  end

  assign clkIf.frameClock = frame_q;
endmodule // apc_clock_gen
`default_nettype wire

// file: apc_adc_path_control_regs.sv
// record-path control register bank with gain staging and clock generation
// assumes the control port presents one access per cycle, synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module apc_adc_path_control_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [6:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  input wire logic bitClkTick,
  output logic left_record_channel_on,
  output logic right_record_channel_on,
  output logic [7:0] left_record_gain,
  output logic [7:0] right_record_gain,
  output logic leftRecordMute,
  output logic rightRecordMute,
  output logic signed [10:0] leftGainEighthsDb,
  output logic signed [10:0] rightGainEighthsDb,
  output logic [3:0] left_sidetone_gain,
  output logic [3:0] right_sidetone_gain,
  output logic [5:0] leftSidetoneAttenDb,
  output logic [5:0] rightSidetoneAttenDb,
  output logic record_clock_invert,
  output logic [2:0] record_rate_divider,
  output logic recordRateTick,
  output logic recordClock,
  output logic record_frame_clock_gen_on,
  output logic [10:0] record_frame_clock_period,
  output logic frame_clock,
  output logic right_second_pin_connect,
  output logic right_first_neg_connect,
  output logic right_first_pos_connect,
  output logic left_second_pin_connect,
  output logic left_first_neg_connect,
  output logic left_first_pos_connect,
  output logic right_aux_amp_on,
  output logic right_aux_resistor_bypass,
  output logic left_aux_amp_on,
  output logic left_aux_resistor_bypass
);
  logic leftOn_q, leftOn_d, rightOn_q, rightOn_d;
  logic [7:0] leftPend_q, leftPend_d, rightPend_q, rightPend_d;
  logic [7:0] leftAct_q, leftAct_d, rightAct_q, rightAct_d;
  logic [3:0] leftSide_q, leftSide_d, rightSide_q, rightSide_d;
  logic clkInv_q, clkInv_d;
  logic [2:0] rateDiv_q, rateDiv_d;
  logic frameOn_q, frameOn_d;
  logic [10:0] period_q, period_d;
  logic [5:0] route_q, route_d;
  logic [3:0] aux_q, aux_d;
  logic [15:0] rd_q, rd_d;
  logic wrLeft, wrRight, updateHit;

  apc_clk_if clkIf ();

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_comb begin
    wrLeft = regWrEn && (regAddr == apc_pkg::ADDR_LEFT_GAIN);
    wrRight = regWrEn && (regAddr == apc_pkg::ADDR_RIGHT_GAIN);
    updateHit = (wrLeft || wrRight) && regWrData[apc_pkg::BIT_VOLUME_UPDATE]; // R1
    leftOn_d = leftOn_q;
    rightOn_d = rightOn_q;
    leftPend_d = leftPend_q;
    rightPend_d = rightPend_q;
    leftSide_d = leftSide_q;
    rightSide_d = rightSide_q;
    clkInv_d = clkInv_q;
    rateDiv_d = rateDiv_q;
    frameOn_d = frameOn_q;
    period_d = period_q;
    route_d = route_q;
    aux_d = aux_q;
    if (wrLeft) begin
      leftOn_d = regWrData[apc_pkg::BIT_CHANNEL_ON]; // R12
      leftPend_d = regWrData[7:0]; // R12
    end else if (wrRight) begin
      rightOn_d = regWrData[apc_pkg::BIT_CHANNEL_ON]; // R13
      rightPend_d = regWrData[7:0]; // R2
    end else if (regWrEn && regAddr == apc_pkg::ADDR_DIV_SIDETONE) begin
      leftSide_d = regWrData[11:8]; // R3
      rightSide_d = regWrData[7:4]; // R4
      clkInv_d = regWrData[apc_pkg::BIT_CLOCK_INVERT]; // R13
      rateDiv_d = regWrData[2:0]; // R5
    end else if (regWrEn && regAddr == apc_pkg::ADDR_FRAME_RATE) begin
      frameOn_d = regWrData[apc_pkg::BIT_FRAME_GEN_ON]; // R6
      period_d = regWrData[10:0]; // R7
    end else if (regWrEn && regAddr == apc_pkg::ADDR_ROUTING) begin
      route_d = {regWrData[apc_pkg::BIT_RIGHT_SECOND], regWrData[apc_pkg::BIT_RIGHT_NEG],
        regWrData[apc_pkg::BIT_RIGHT_POS], regWrData[apc_pkg::BIT_LEFT_SECOND],
        regWrData[apc_pkg::BIT_LEFT_NEG], regWrData[apc_pkg::BIT_LEFT_POS]}; // R8 R9
    end else if (regWrEn && regAddr == apc_pkg::ADDR_AUX_AMP) begin
      aux_d = {regWrData[apc_pkg::BIT_RIGHT_AUX_ON], regWrData[apc_pkg::BIT_RIGHT_AUX_BYPASS],
        regWrData[apc_pkg::BIT_LEFT_AUX_ON], regWrData[apc_pkg::BIT_LEFT_AUX_BYPASS]}; // R10 R11
    end
    // the gain written with the update bit takes effect in the same transfer
    leftAct_d = updateHit ? leftPend_d : leftAct_q; // R1 R14
    rightAct_d = updateHit ? rightPend_d : rightAct_q; // R1 R14
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      leftOn_q <= 1'b0;
      rightOn_q <= 1'b0;
      leftPend_q <= apc_pkg::RST_GAIN;
      rightPend_q <= apc_pkg::RST_GAIN;
      leftAct_q <= apc_pkg::RST_GAIN;
      rightAct_q <= apc_pkg::RST_GAIN;
      leftSide_q <= 4'h0;
      rightSide_q <= 4'h0;
      clkInv_q <= 1'b0;
      rateDiv_q <= 3'h0;
      frameOn_q <= 1'b0;
      period_q <= apc_pkg::RST_FRAME_PERIOD;
      route_q <= apc_pkg::RST_ROUTING;
      aux_q <= 4'h0;
    end else begin
      leftOn_q <= leftOn_d;
      rightOn_q <= rightOn_d;
      leftPend_q <= leftPend_d;
      rightPend_q <= rightPend_d;
      leftAct_q <= leftAct_d;
      rightAct_q <= rightAct_d;
      leftSide_q <= leftSide_d;
      rightSide_q <= rightSide_d;
      clkInv_q <= clkInv_d;
      rateDiv_q <= rateDiv_d;
      frameOn_q <= frameOn_d;
      period_q <= period_d;
      route_q <= route_d;
      aux_q <= aux_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads: one cycle after regRdEn, unmapped reads return zero
  always_comb begin
    rd_d = rd_q;
    if (regRdEn) begin
      if (regAddr == apc_pkg::ADDR_LEFT_GAIN) begin
        rd_d = {leftOn_q, 7'h00, leftPend_q}; // R14
      end else if (regAddr == apc_pkg::ADDR_RIGHT_GAIN) begin
        rd_d = {rightOn_q, 7'h00, rightPend_q}; // R14
      end else if (regAddr == apc_pkg::ADDR_DIV_SIDETONE) begin
        rd_d = {4'h0, leftSide_q, rightSide_q, clkInv_q, rateDiv_q};
      end else if (regAddr == apc_pkg::ADDR_FRAME_RATE) begin
        rd_d = {4'h0, frameOn_q, period_q};
      end else if (regAddr == apc_pkg::ADDR_ROUTING) begin
        rd_d = {5'h00, route_q[5:3], 5'h00, route_q[2:0]};
      end else if (regAddr == apc_pkg::ADDR_AUX_AMP) begin
        rd_d = {aux_q[3:2], 6'h00, aux_q[1:0], 6'h00};
      end else begin
        rd_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 16'h0000;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign regRdData = rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls
  assign left_record_channel_on = leftOn_q; // R12
  assign right_record_channel_on = rightOn_q; // R13
  assign left_record_gain = leftAct_q;
  assign right_record_gain = rightAct_q;
  assign leftRecordMute = (leftAct_q == 8'h00); // R12
  assign rightRecordMute = (rightAct_q == 8'h00); // R2
  // three eighths of a dB per code; only meaningful when not muted
  assign leftGainEighthsDb = $signed({3'h0, leftAct_q} + {2'h0, leftAct_q, 1'b0}
    - apc_pkg::GAIN_EIGHTHS_OFFSET); // R12
  assign rightGainEighthsDb = $signed({3'h0, rightAct_q} + {2'h0, rightAct_q, 1'b0}
    - apc_pkg::GAIN_EIGHTHS_OFFSET); // R2
  assign left_sidetone_gain = leftSide_q;
  assign right_sidetone_gain = rightSide_q;
  // codes above 12 saturate at 0dB
  assign leftSidetoneAttenDb = (leftSide_q >= apc_pkg::SIDETONE_ZERO_CODE) ? 6'h00 :
    apc_pkg::SIDETONE_MAX_ATTEN - ({2'h0, leftSide_q} + {1'h0, leftSide_q, 1'b0}); // R3
  assign rightSidetoneAttenDb = (rightSide_q >= apc_pkg::SIDETONE_ZERO_CODE) ? 6'h00 :
    apc_pkg::SIDETONE_MAX_ATTEN - ({2'h0, rightSide_q} + {1'h0, rightSide_q, 1'b0}); // R4
  assign record_clock_invert = clkInv_q;
  assign record_rate_divider = rateDiv_q;
  assign record_frame_clock_gen_on = frameOn_q;
  assign record_frame_clock_period = period_q;
  assign {right_second_pin_connect, right_first_neg_connect, right_first_pos_connect,
    left_second_pin_connect, left_first_neg_connect, left_first_pos_connect} = route_q; // R8 R9
  assign {right_aux_amp_on, right_aux_resistor_bypass,
    left_aux_amp_on, left_aux_resistor_bypass} = aux_q; // R10 R11

  ////////////////////////////////////////////////////////////////////////////
  // clock generation
  assign clkIf.rateCode = rateDiv_q;
  assign clkIf.clockInvert = clkInv_q;
  assign clkIf.frameGenOn = frameOn_q;
  assign clkIf.framePeriod = period_q;

  apc_clock_gen clockGen (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bitClkTick(bitClkTick),
    .clkIf(clkIf)
  );

  assign recordRateTick = clkIf.rateTick;
  assign recordClock = clkIf.recordClock;
  assign frame_clock = clkIf.frameClock;
endmodule // apc_adc_path_control_regs
`default_nettype wire

// file: apc_regs_chk.sv
// assertion checker for the record-path register bank
// assumes one core_clk domain; bound onto the bank's top module
`timescale 1ns/1ps
`default_nettype none
module apc_regs_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [6:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic left_record_channel_on,
  input wire logic [7:0] left_record_gain,
  input wire logic [7:0] right_record_gain,
  input wire logic rightRecordMute,
  input wire logic signed [10:0] rightGainEighthsDb,
  input wire logic [3:0] left_sidetone_gain,
  input wire logic [5:0] leftSidetoneAttenDb,
  input wire logic [2:0] record_rate_divider,
  input wire logic recordRateTick,
  input wire logic record_frame_clock_gen_on,
  input wire logic frame_clock,
  input wire logic right_second_pin_connect,
  input wire logic right_first_neg_connect,
  input wire logic right_first_pos_connect,
  input wire logic left_second_pin_connect,
  input wire logic left_first_neg_connect,
  input wire logic left_first_pos_connect
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic updW;
  logic [5:0] route;
  logic [5:0] wrRoute;
  logic [10:0] eR;
  logic [5:0] stExp;
  // 0x42 and 0x43 differ only in bit 0
  assign updW = regWrEn && regWrData[8] && regAddr[6:1] == 6'h21;
  assign route = {right_second_pin_connect, right_first_neg_connect, right_first_pos_connect,
    left_second_pin_connect, left_first_neg_connect, left_first_pos_connect};
  assign wrRoute = {regWrData[10:8], regWrData[2:0]};
  assign eR = 11'(right_record_gain) * 11'h003 - 11'h240;
  assign stExp = (left_sidetone_gain >= 4'hC) ? 6'h00 : 6'h24 - 6'(left_sidetone_gain) * 6'h03;
  ////////////////////////////////////////
  a_gain_hold: assert property (
    !updW |=> $stable(left_record_gain) && $stable(right_record_gain))
    else $error("active gain moved without update");
  a_update_pair: assert property (
    updW && regAddr[0] |=> right_record_gain == $past(regWrData[7:0]))
    else $error("update did not load new gain");
  a_gain_map: assert property (
    rightGainEighthsDb == $signed(eR) && rightRecordMute == (right_record_gain == 8'h00))
    else $error("gain code mapping wrong");
  a_sidetone_map: assert property (leftSidetoneAttenDb == stExp)
    else $error("side-tone attenuation wrong");
  a_rate_halt: assert property ((record_rate_divider == 3'h7) [*3] |-> !recordRateTick)
    else $error("tick on reserved rate code");
  a_rate_full: assert property ((record_rate_divider == 3'h0) [*5] |-> recordRateTick)
    else $error("divide by one missed a tick");
  a_frame_off: assert property ((!record_frame_clock_gen_on) [*2] |-> !frame_clock)
    else $error("frame clock while disabled");
  a_route_write: assert property (regWrEn && regAddr == 7'h48 |=> route == $past(wrRoute))
    else $error("routing bits not stored");
  a_read_route: assert property (
    regRdEn && regAddr == 7'h48 |=>
    regRdData == {5'h00, $past(route[5:3]), 5'h00, $past(route[2:0])})
    else $error("routing readback wrong");
  a_left_enable: assert property (
    regWrEn && regAddr == 7'h42 |=> left_record_channel_on == $past(regWrData[15]))
    else $error("left enable not stored");
  a_vu_reads_zero: assert property (regRdEn && regAddr[6:1] == 6'h21 |=> !regRdData[8])
    else $error("update bit read back set");
  c_update: cover property (updW);
  c_rate_odd: cover property (record_rate_divider == 3'h5 && recordRateTick);
  c_frame: cover property ($rose(frame_clock));
endmodule // apc_regs_chk
bind apc_adc_path_control_regs apc_regs_chk u_apc_regs_chk (.core_clk, .rst_n, .regWrEn,
  .regRdEn, .regAddr, .regWrData, .regRdData, .left_record_channel_on, .left_record_gain,
  .right_record_gain, .rightRecordMute, .rightGainEighthsDb, .left_sidetone_gain,
  .leftSidetoneAttenDb, .record_rate_divider, .recordRateTick, .record_frame_clock_gen_on,
  .frame_clock, .right_second_pin_connect, .right_first_neg_connect, .right_first_pos_connect,
  .left_second_pin_connect, .left_first_neg_connect, .left_first_pos_connect);
`default_nettype wire

// file: tb_apc_adc_path_control_regs.sv
// self-checking bench for the record-path register bank
// assumes only the bank's ports; an integer model of the registers is kept here
`timescale 1ns/1ps
`default_nettype none
module tb_apc_adc_path_control_regs;
  logic core_clk, rst_n, regWrEn, regRdEn, bitClkTick, fc, rc;
  logic [6:0] regAddr, a;
  logic [15:0] regWrData, regRdData, d;
  logic left_record_channel_on, right_record_channel_on, leftRecordMute, rightRecordMute;
  logic [7:0] left_record_gain, right_record_gain;
  logic signed [10:0] leftGainEighthsDb, rightGainEighthsDb;
  logic [3:0] left_sidetone_gain, right_sidetone_gain, ax;
  logic [5:0] leftSidetoneAttenDb, rightSidetoneAttenDb, rt;
  logic record_clock_invert, recordRateTick, record_frame_clock_gen_on, frame_clock, recordClock;
  logic [2:0] record_rate_divider;
  logic [10:0] record_frame_clock_period;
  logic right_second_pin_connect, right_first_neg_connect, right_first_pos_connect;
  logic left_second_pin_connect, left_first_neg_connect, left_first_pos_connect;
  logic right_aux_amp_on, right_aux_resistor_bypass, left_aux_amp_on, left_aux_resistor_bypass;
  logic [31:0] seed;
  int err_count = 0, checked = 0, cycles = 0, tc = 0, actL = 'hC0, actR = 'hC0, n, k, e, t;
  int m [int];
  int r2 [8] = '{2, 3, 4, 6, 8, 11, 12, 1};
  logic [6:0] adr [8] = '{7'h42, 7'h43, 7'h44, 7'h46, 7'h48, 7'h49, 7'h45, 7'h4A};
  logic [15:0] rv [8] = '{16'h00C0, 16'h00C0, 16'h0000, 16'h0040, 16'h0303, 16'h0000,
    16'h0000, 16'h0000};
  logic [7:0] gb [3] = '{8'h00, 8'h01, 8'hEF};
  logic [15:0] pv [2] = '{16'h0809, 16'h0803};
  assign rt = {right_second_pin_connect, right_first_neg_connect, right_first_pos_connect,
    left_second_pin_connect, left_first_neg_connect, left_first_pos_connect};
  assign ax = {right_aux_amp_on, right_aux_resistor_bypass, left_aux_amp_on,
    left_aux_resistor_bypass};
  apc_adc_path_control_regs u_apc_adc_path_control_regs (.core_clk, .rst_n, .regWrEn, .regRdEn,
    .regAddr, .regWrData, .regRdData, .bitClkTick, .left_record_channel_on,
    .right_record_channel_on,
    .left_record_gain, .right_record_gain, .leftRecordMute, .rightRecordMute, .leftGainEighthsDb,
    .rightGainEighthsDb, .left_sidetone_gain, .right_sidetone_gain, .leftSidetoneAttenDb,
    .rightSidetoneAttenDb, .record_clock_invert, .record_rate_divider, .recordRateTick,
    .recordClock, .record_frame_clock_gen_on, .record_frame_clock_period, .frame_clock,
    .right_second_pin_connect, .right_first_neg_connect, .right_first_pos_connect,
    .left_second_pin_connect, .left_first_neg_connect, .left_first_pos_connect, .right_aux_amp_on,
    .right_aux_resistor_bypass, .left_aux_amp_on, .left_aux_resistor_bypass);
  ////////////////////////////////////////
  always #2.5 core_clk = ~core_clk;
  // bit clock pulse every third cycle; timeout well above the whole run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    tc <= (tc == 2) ? 0 : tc + 1;
    bitClkTick <= (tc == 2);
    if (cycles == 20000) begin
      err_count++;
      $display("Error at %0t: timeout", $time);
      test_done;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int st(input int c);
    return (c >= 12) ? 0 : 36 - 3 * c;
  endfunction
  // readable bits per register; the update bit is write-only
  function automatic int mask(input logic [6:0] ma);
    case (ma)
      7'h42, 7'h43: return 16'h80FF;
      7'h44, 7'h46: return 16'h0FFF;
      7'h48: return 16'h0707;
      7'h49: return 16'hC0C0;
      default: return 0;
    endcase
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    checked++;
    if (seen !== expv) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, expv);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // strobe is left high so consecutive calls give back-to-back writes
  task automatic wr(input logic [6:0] wa, input logic [15:0] wd);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regRdEn <= 1'b0;
    regAddr <= wa;
    regWrData <= wd;
    m[wa] = wd & mask(wa);
    if (wd[8] && wa[6:1] == 6'h21) begin
      actL = m[7'h42] & 16'h00FF;
      actR = m[7'h43] & 16'h00FF;
    end
  endtask
  task automatic rd(input logic [6:0] ra);
    @(posedge core_clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    regAddr <= ra;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, 16'(m[ra]));
  endtask
  task automatic check_outs;
    int sc, fr, rg, au;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    #1;
    sc = m[7'h44];
    fr = m[7'h46];
    rg = m[7'h48];
    au = m[7'h49];
    chk({left_record_gain, right_record_gain}, 16'(actL * 256 + actR));
    chk(16'(leftGainEighthsDb), 16'(actL * 3 - 576));
    chk(16'(rightGainEighthsDb), 16'(actR * 3 - 576));
    chk({leftRecordMute, rightRecordMute}, {actL == 0, actR == 0});
    chk({left_record_channel_on, right_record_channel_on}, {m[7'h42][15], m[7'h43][15]});
    chk({leftSidetoneAttenDb, rightSidetoneAttenDb}, 16'(st(sc[11:8]) * 64 + st(sc[7:4])));
    chk({left_sidetone_gain, right_sidetone_gain}, sc[11:4]);
    chk({record_clock_invert, record_rate_divider}, sc[3:0]);
    chk({record_frame_clock_gen_on, record_frame_clock_period}, fr[11:0]);
    chk(rt, {rg[10:8], rg[2:0]});
    chk(ax, {au[15:14], au[7:6]});
  endtask
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 7'h00;
    regWrData = 16'h0000;
    bitClkTick = 1'b0;
    seed = 32'h4E25;
    foreach (adr[i]) m[adr[i]] = rv[i];
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    check_outs;
    foreach (adr[i]) rd(adr[i]);
    // random traffic; reserved rate code and short periods kept out here
    repeat (60) begin
      repeat (5) seed = lfsr(seed);
      a = adr[seed[2:0]];
      d = seed[31:16];
      if (a == 7'h44 && d[2:0] == 3'h7) d[2:0] = 3'h5;
      d[3] = d[3] | (a == 7'h46);
      wr(a, d);
      if (seed[5]) wr(a, d ^ 16'h0100);
      check_outs;
      rd(a);
    end
    foreach (gb[i]) begin
      wr(7'h42, 16'h8100 | gb[i]);
      check_outs;
    end
    wr(7'h43, 16'h0055);
    wr(7'h42, 16'h0112);
    check_outs;
    for (int c = 0; c < 8; c++) begin
      wr(7'h44, 16'(c));
      check_outs;
      repeat (20) @(posedge core_clk);
      #1;
      n = 0;
      t = 0;
      rc = recordClock;
      repeat (132) begin
        @(posedge core_clk);
        #1;
        n += recordRateTick;
        t += recordClock ^ rc;
        rc = recordClock;
      end
      e = (c == 7) ? 0 : 264 / r2[c];
      chk(16'(n + 1 >= e && n <= e + 1), 16'h0001);
      chk(16'(t), 16'(n));
    end
    // divider halted on the reserved code, so only the invert bit can move the record clock
    rc = recordClock;
    wr(7'h44, 16'h000F);
    check_outs;
    chk(16'(recordClock ^ rc), 16'h0001);
    // period 9 is expected to give nine bit clocks per phase, and short code 3 to behave as eight
    foreach (pv[i]) begin
      wr(7'h46, pv[i]);
      @(posedge core_clk);
      regWrEn <= 1'b0;
      repeat (60) @(posedge core_clk);
      #1;
      fc = frame_clock;
      k = 0;
      n = 0;
      while (frame_clock === fc && k < 200) begin
        @(posedge core_clk);
        #1;
        k++;
      end
      fc = frame_clock;
      while (frame_clock === fc && k < 400) begin
        @(posedge core_clk);
        #1;
        n += bitClkTick;
        k++;
      end
      chk(16'(n), (i == 0) ? 16'h0009 : 16'h0008);
    end
    wr(7'h46, 16'h0040);
    check_outs;
    repeat (3) @(posedge core_clk);
    chk(16'(frame_clock), 16'h0000);
    test_done;
  end
endmodule // tb_apc_adc_path_control_regs
`default_nettype wire
